// ==== rtl/rism_irq_map.v ====
// Operation
// (RL1) x counter register, frequency two, 0x74
// (RL2) y counter register, frequency two, 0x62
// (RL3) z counter register, frequency two, 0x32
// (RL4) bits 4:3 pick amplifier ramp time
// (RL5) bit 2 picks low rx current
// (RL6) continuous: line a strength or start
// (RL7) buffered: line a low/byte/notempty/start
// (RL8) packet: line a ready/byte/notempty
// (RL9) packet code 11: address match or start
// (RL10) continuous: line b is data clock
// (RL11) buffered: line b low/full/strength/threshold
// (RL12) packet: line b crc/full/strength/threshold
// (RL13) packet enable overrides mode bit
// (RL14) threshold event at threshold plus one
// (RL15) frequency select picks counter set
// (RL16) interrupt lines are registered outputs
`include "rism_map.vh"
`timescale 1ns/1ps
`default_nettype none
module rism_irq_map #(
    parameter FIFO_CW = 7
) (
    // apb slave side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // receive event sources and fifo fill
    input wire [23:0] freq1_counters,
    input wire start_detect,
    input wire signal_strength_event,
    input wire write_byte_event,
    input wire fifo_not_empty_flag,
    input wire fifo_full_flag,
    input wire payload_ready_event,
    input wire crc_valid_event,
    input wire node_address_match,
    input wire recovered_data_clock,
    input wire [FIFO_CW-1:0] fifo_count,
    // host lines and synthesizer settings
    output reg host_irq_line_a,
    output reg host_irq_line_b,
    output reg [23:0] synth_counters,
    output reg [1:0] amp_ramp_time,
    output reg [15:0] amp_ramp_cycles,
    output reg rx_low_current,
    output wire irq
);
// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] freq2_x_value; // x counter, frequency two
reg [7:0] freq2_y_value; // y counter
reg [7:0] freq2_z_value; // z counter
reg [7:0] amp_cfg; // ramp and rx current
reg [7:0] irq_sel; // line selectors
reg [7:0] ctrl; // mode, packet, address, freq
reg [7:0] fifo_thresh; // threshold value
reg [7:0] status; // sticky events
reg [7:0] mask; // interrupt mask
reg [7:0] ev_prev; // last event levels
wire [7:0] ev_now; // current event levels
reg next_line_a; // line a source
reg next_line_b; // line b source
reg [15:0] next_ramp; // ramp cycle count
wire [1:0] rx_line_a_selector;
wire [1:0] rx_line_b_selector;
wire packet_handling_enable;
wire buffered_mode;
wire address_compare_enable;
wire frequency_select;
wire fifo_thresh_event;
wire wr_en;
wire rd_en;
wire [7:0] addr_idx;
wire addr_ok;
wire stat_rd; // access edge of a status read
localparam EV_W = 8; // number of sticky events
genvar gi; // status bit index
assign rx_line_a_selector = irq_sel[`RISM_SEL_A_HI:`RISM_SEL_A_LO];
assign rx_line_b_selector = irq_sel[`RISM_SEL_B_HI:`RISM_SEL_B_LO];
assign buffered_mode = ctrl[`RISM_CTRL_MODE];
assign packet_handling_enable = ctrl[`RISM_CTRL_PKT];
assign address_compare_enable = ctrl[`RISM_CTRL_ADDR];
assign frequency_select = ctrl[`RISM_CTRL_FREQ];
// (RL14) threshold plus one bytes
// both sides widened to FIFO_CW plus eight bits
assign fifo_thresh_event = ({{8{1'b0}}, fifo_count} > {{FIFO_CW{1'b0}}, fifo_thresh});
// ----------------------------------------
// apb decode
// ----------------------------------------
assign addr_idx = paddr[9:2];
// mapped words only, upper bits and low two bits zero
assign addr_ok = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'b00) &&
    ((addr_idx >= `RISM_IDX_X && addr_idx <= `RISM_IDX_IRQSEL) ||
     (addr_idx >= `RISM_IDX_CTRL && addr_idx <= `RISM_IDX_PINS));
// every access ends at its first access edge
assign pready = 1'b1; // zero wait states
assign pslverr = psel & penable & ~addr_ok; // unmapped address
assign wr_en = psel & penable & pwrite & addr_ok;
assign rd_en = psel & penable & ~pwrite & addr_ok;
assign stat_rd = rd_en && (addr_idx == `RISM_IDX_STAT);
// event levels that feed the sticky status
assign ev_now = {fifo_thresh_event, crc_valid_event, payload_ready_event,
    node_address_match, fifo_full_flag, write_byte_event,
    signal_strength_event, start_detect};
// high while any unmasked status bit is set
assign irq = |(status & mask); // level interrupt
// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        freq2_x_value <= `RISM_RST_X;
        freq2_y_value <= `RISM_RST_Y;
        freq2_z_value <= `RISM_RST_Z;
        amp_cfg <= `RISM_RST_AMP;
        irq_sel <= `RISM_RST_IRQSEL;
        ctrl <= `RISM_RST_CTRL;
        fifo_thresh <= `RISM_RST_FIFO;
        mask <= `RISM_RST_MASK;
    end else if (wr_en) begin
        case (addr_idx)
            // (RL1) x counter write
            `RISM_IDX_X: freq2_x_value <= pwdata[7:0];
            // (RL2) y counter write
            `RISM_IDX_Y: freq2_y_value <= pwdata[7:0];
            // (RL3) z counter write
            `RISM_IDX_Z: freq2_z_value <= pwdata[7:0];
            // (RL5) unused bits dropped
            `RISM_IDX_AMP: amp_cfg <= pwdata[7:0] & `RISM_AMP_MASK;
            // only the two selector fields kept
            `RISM_IDX_IRQSEL: irq_sel <= pwdata[7:0] & `RISM_SEL_MASK;
            // mode, packet, address and frequency bits
            `RISM_IDX_CTRL: ctrl <= pwdata[7:0] & `RISM_CTRL_MASK;
            // six-bit fill threshold
            `RISM_IDX_FIFO: fifo_thresh <= pwdata[7:0] & `RISM_FIFO_MASK;
            // one enable per status bit
            `RISM_IDX_MASK: mask <= pwdata[7:0];
            // read-only words and holes ignore writes
            default: begin
            end
        endcase
    end
end
// ----------------------------------------
// sticky status, set beats read clear
// ----------------------------------------
// one flop pair per event; a read clears only the bits that it
// returned, so an edge landing between setup and access survives
generate
    for (gi = 0; gi < EV_W; gi = gi + 1) begin : g_stat
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                status[gi] <= 1'b0;
                ev_prev[gi] <= 1'b0;
            end else begin
                // last level for edge detection
                ev_prev[gi] <= ev_now[gi];
                if (ev_now[gi] && !ev_prev[gi]) begin
                    // a fresh rising edge always sets
                    status[gi] <= 1'b1;
                end else if (stat_rd && prdata[gi]) begin
                    // read clear of a reported bit
                    status[gi] <= 1'b0;
                end
            end
        end
    end
endgenerate
// ----------------------------------------
// read data
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
        case (addr_idx)
            `RISM_IDX_X: prdata <= {24'h000000, freq2_x_value};
            `RISM_IDX_Y: prdata <= {24'h000000, freq2_y_value};
            `RISM_IDX_Z: prdata <= {24'h000000, freq2_z_value};
            `RISM_IDX_AMP: prdata <= {24'h000000, amp_cfg};
            `RISM_IDX_IRQSEL: prdata <= {24'h000000, irq_sel};
            `RISM_IDX_CTRL: prdata <= {24'h000000, ctrl};
            `RISM_IDX_FIFO: prdata <= {24'h000000, fifo_thresh};
            // snapshot that the access edge then clears
            `RISM_IDX_STAT: prdata <= {24'h000000, status};
            `RISM_IDX_MASK: prdata <= {24'h000000, mask};
            // present line levels
            `RISM_IDX_PINS: prdata <= {30'h00000000, host_irq_line_b, host_irq_line_a};
            // holes read zero; misaligned addresses, and addresses with upper bits set, read the word at paddr[9:2]
            default: prdata <= 32'h00000000;
        endcase
    end
end
// ----------------------------------------
// line source selection
// ----------------------------------------
always @* begin
    next_line_a = 1'b0;
    next_line_b = 1'b0;
    // (RL13) packet enable first
    if (packet_handling_enable) begin
        // (RL8) packet line a
        case (rx_line_a_selector)
            // payload complete
            `RISM_SEL_0: next_line_a = payload_ready_event;
            // each byte written
            `RISM_SEL_1: next_line_a = write_byte_event;
            // fifo holds data
            `RISM_SEL_2: next_line_a = fifo_not_empty_flag;
            // (RL9) address match or start
            default: next_line_a = address_compare_enable ? node_address_match
                : start_detect;
        endcase
        // (RL12) packet line b
        case (rx_line_b_selector)
            // crc passed
            `RISM_SEL_0: next_line_b = crc_valid_event;
            // fifo full
            `RISM_SEL_1: next_line_b = fifo_full_flag;
            // signal above threshold
            `RISM_SEL_2: next_line_b = signal_strength_event;
            // (RL14) fill threshold reached
            default: next_line_b = fifo_thresh_event;
        endcase
    end else if (buffered_mode) begin
        // (RL7) buffered line a
        case (rx_line_a_selector)
            // line held low
            `RISM_SEL_0: next_line_a = 1'b0;
            // each byte written
            `RISM_SEL_1: next_line_a = write_byte_event;
            // fifo holds data
            `RISM_SEL_2: next_line_a = fifo_not_empty_flag;
            // start pattern seen
            default: next_line_a = start_detect;
        endcase
        // (RL11) buffered line b
        case (rx_line_b_selector)
            // line held low
            `RISM_SEL_0: next_line_b = 1'b0;
            // fifo full
            `RISM_SEL_1: next_line_b = fifo_full_flag;
            // signal above threshold
            `RISM_SEL_2: next_line_b = signal_strength_event;
            // fill threshold reached
            default: next_line_b = fifo_thresh_event;
        endcase
    end else begin
        // (RL6) continuous line a
        next_line_a = (rx_line_a_selector == `RISM_SEL_1) ? signal_strength_event
            : start_detect;
        // (RL10) data clock on line b
        next_line_b = recovered_data_clock;
    end
end
// ----------------------------------------
// ramp time to cycles, rounded up
// ----------------------------------------
always @* begin
    // (RL4) ramp code decode
    case (amp_cfg[`RISM_AMP_RAMP_HI:`RISM_AMP_RAMP_LO])
        `RISM_SEL_0: next_ramp = `RISM_RAMP_C0;
        `RISM_SEL_1: next_ramp = `RISM_RAMP_C1;
        `RISM_SEL_2: next_ramp = `RISM_RAMP_C2;
        default: next_ramp = `RISM_RAMP_C3;
    endcase
end
// ----------------------------------------
// registered outputs
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        host_irq_line_a <= 1'b0;
        host_irq_line_b <= 1'b0;
        synth_counters <= 24'h000000;
        amp_ramp_time <= 2'b00;
        amp_ramp_cycles <= 16'h0000;
        rx_low_current <= 1'b0;
    end else begin
        // (RL16) glitch-free line outputs
        host_irq_line_a <= next_line_a;
        host_irq_line_b <= next_line_b;
        // (RL15) counter set choice
        synth_counters <= frequency_select
            ? {freq2_x_value, freq2_y_value, freq2_z_value} : freq1_counters;
        // (RL4) ramp code and length
        amp_ramp_time <= amp_cfg[`RISM_AMP_RAMP_HI:`RISM_AMP_RAMP_LO];
        amp_ramp_cycles <= next_ramp;
        // (RL5) rx current level
        rx_low_current <= amp_cfg[`RISM_AMP_RXCUR];
    end
end
endmodule
`default_nettype wire

// ==== rtl/rism_map.vh ====
`ifndef RISM_MAP_VH
`define RISM_MAP_VH
// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define RISM_IDX_X 8'h09
`define RISM_IDX_Y 8'h0a
`define RISM_IDX_Z 8'h0b
`define RISM_IDX_AMP 8'h0c
`define RISM_IDX_IRQSEL 8'h0d
`define RISM_IDX_CTRL 8'h10
`define RISM_IDX_FIFO 8'h11
`define RISM_IDX_STAT 8'h12
`define RISM_IDX_MASK 8'h13
`define RISM_IDX_PINS 8'h14
// ----------------------------------------
// reset values
// ----------------------------------------
`define RISM_RST_X 8'h74
`define RISM_RST_Y 8'h62
`define RISM_RST_Z 8'h32
`define RISM_RST_AMP 8'h18
`define RISM_RST_IRQSEL 8'h00
`define RISM_RST_CTRL 8'h00
`define RISM_RST_FIFO 8'h0f
`define RISM_RST_MASK 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define RISM_AMP_RAMP_HI 4
`define RISM_AMP_RAMP_LO 3
`define RISM_AMP_RXCUR 2
`define RISM_AMP_MASK 8'h1c
`define RISM_SEL_A_HI 7
`define RISM_SEL_A_LO 6
`define RISM_SEL_B_HI 5
`define RISM_SEL_B_LO 4
`define RISM_SEL_MASK 8'hf0
`define RISM_CTRL_MODE 0
`define RISM_CTRL_PKT 1
`define RISM_CTRL_ADDR 2
`define RISM_CTRL_FREQ 3
`define RISM_CTRL_MASK 8'h0f
`define RISM_FIFO_MASK 8'h3f
// ----------------------------------------
// selector codes
// ----------------------------------------
`define RISM_SEL_0 2'b00
`define RISM_SEL_1 2'b01
`define RISM_SEL_2 2'b10
`define RISM_SEL_3 2'b11
// ----------------------------------------
// ramp lengths in pclk cycles at 125 MHz, rounded up
// ----------------------------------------
`define RISM_RAMP_C0 16'h0177
`define RISM_RAMP_C1 16'h0427
`define RISM_RAMP_C2 16'h0753
`define RISM_RAMP_C3 16'h0b3b
`endif

// ==== verif/rism_irq_map_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// bus and ramp checker, top ports only
module rism_irq_map_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] amp_ramp_time,
    input wire logic [15:0] amp_ramp_cycles,
    input wire logic rx_low_current
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access edge of a ramp register write
    sequence s_amp_wr;
        psel && penable && pwrite && paddr == 32'h30;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    a_err_hole: assert property (psel && penable && paddr == 32'h20 |-> pslverr)
        else $error("unmapped access not refused");
    a_map_ok: assert property (psel && penable && paddr inside {32'h24, 32'h28, 32'h2c,
        32'h30} |-> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    a_rd_stable: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved without read");
    a_ramp_write: assert property (s_amp_wr |-> ##2 amp_ramp_time == $past(pwdata[4:3], 2))
        else $error("ramp code not taken");
    a_rxcur_write: assert property (s_amp_wr |-> ##2 rx_low_current == $past(pwdata[2], 2))
        else $error("rx current not taken");
    a_ramp_table: assert property (amp_ramp_cycles != 16'h0 |-> amp_ramp_cycles ==
        (amp_ramp_time == 2'h0 ? 16'd375 : amp_ramp_time == 2'h1 ? 16'd1063 :
        amp_ramp_time == 2'h2 ? 16'd1875 : 16'd2875))
        else $error("ramp length wrong");
endmodule
`default_nettype wire

// ==== verif/rism_host_mdl.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side: samples both interrupt lines each clock
module rism_host_mdl (
    input wire logic pclk,
    input wire logic line_a,
    input wire logic line_b,
    output logic seen_a,
    output logic seen_b
);
    always @(posedge pclk) begin
        seen_a <= line_a;
        seen_b <= line_b;
    end
endmodule
`default_nettype wire

// ==== verif/rism_irq_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rism_irq_map_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, la, lb, sa, sb, rxc, e;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [8:0] src; // event levels, one bit each
    logic [6:0] fifo_count;
    logic [23:0] synth;
    logic [1:0] ramp;
    logic [15:0] rcyc;
    int err_total = 0, num_checks = 0, cyc = 0;
    rism_irq_map dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .freq1_counters(24'habcdef), .start_detect(src[0]),
        .signal_strength_event(src[1]), .write_byte_event(src[2]),
        .fifo_not_empty_flag(src[3]), .fifo_full_flag(src[4]), .payload_ready_event(src[5]),
        .crc_valid_event(src[6]), .node_address_match(src[7]), .recovered_data_clock(src[8]),
        .fifo_count(fifo_count), .host_irq_line_a(la), .host_irq_line_b(lb),
        .synth_counters(synth), .amp_ramp_time(ramp), .amp_ramp_cycles(rcyc),
        .rx_low_current(rxc), .irq(irq));
    rism_host_mdl host_u (.pclk(pclk), .line_a(la), .line_b(lb), .seen_a(sa), .seen_b(sb));
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            print_verdict;
        end
    end
    task print_verdict;
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            err_total++;
            $display("Error %s exp %h seen %h", n, x, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, waits on pready
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic t_regs;
        logic [31:0] ad [5] = '{32'h24, 32'h28, 32'h2c, 32'h30, 32'h44};
        logic [7:0] rv [5] = '{8'h74, 8'h62, 8'h32, 8'h18, 8'h0f};
        chk("freq one", synth, 24'habcdef);
        for (int i = 0; i < 5; i++) begin
            apb(0, ad[i], 0);
            chk("reset val", rd, {24'h0, rv[i]});
        end
        for (int i = 0; i < 3; i++) begin
            apb(1, ad[i], 32'h1a + i);
            apb(0, ad[i], 0);
            chk("rw val", rd, 32'h1a + i);
        end
        apb(1, 32'h40, 32'h08);
        tick(1);
        chk("freq two", synth, 24'h1a1b1c);
        apb(1, 32'h30, 32'hff);
        apb(0, 32'h30, 0);
        chk("amp bits", rd, 32'h1c);
        chk("low cur", rxc, 1);
        apb(0, 32'h20, 0);
        chk("hole err", e, 1);
    endtask
    task automatic t_ramp;
        logic [15:0] t [4] = '{16'd375, 16'd1063, 16'd1875, 16'd2875};
        for (int c = 0; c < 4; c++) begin
            apb(1, 32'h30, {27'h0, c[1:0], 3'h0});
            tick(1);
            chk("ramp code", ramp, c[1:0]);
            chk("ramp len", rcyc, t[c]);
        end
    endtask
    task t_irq;
        apb(1, 32'h4c, 32'h01);
        src <= 9'h002;
        tick(3);
        chk("irq masked", irq, 0);
        src <= 9'h003;
        tick(3);
        chk("irq up", irq, 1);
        apb(0, 32'h50, 0);
        chk("pins", rd, 32'h01);
        apb(0, 32'h48, 0);
        chk("status", rd, 32'h03);
        src <= 9'h000;
        tick(2);
        chk("irq clear", irq, 0);
        apb(0, 32'h48, 0);
        chk("status clear", rd, 32'h00);
    endtask
    // one source on (or all but it), then wait for the host view
    task drive(input logic [3:0] k, input logic on);
        src <= on ? 9'(1 << k) : ~9'(1 << k);
        fifo_count <= ((k == 4'd9) == on) ? 7'd16 : 7'd15;
        tick(3);
    endtask
    task automatic t_route;
        logic [63:0] ta = 64'h7325_0325_032a_0010, tb = 64'h9146_9146_914a_8888;
        logic [7:0] cfg [4] = '{8'h00, 8'h01, 8'h02, 8'h06};
        logic [3:0] xa, xb;
        for (int i = 0; i < 16; i++) begin
            xa = ta[4*i +: 4];
            xb = tb[4*i +: 4];
            apb(1, 32'h40, {24'h0, cfg[i/4]});
            apb(1, 32'h34, {24'h0, i[1:0], i[1:0], 4'h0});
            for (int v = 0; v < 2; v++) begin
                drive(xa, v[0]);
                chk("line a", sa, v[0] && xa != 4'ha);
                drive(xb, v[0]);
                chk("line b", sb, v[0] && xb != 4'ha);
            end
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, src, fifo_count} = '0;
        tick(10);
        presetn <= 1;
        tick(3);
        t_regs;
        t_ramp;
        t_irq;
        t_route;
        print_verdict;
    end
endmodule
bind rism_irq_map rism_irq_map_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amp_ramp_time(amp_ramp_time),
    .amp_ramp_cycles(amp_ramp_cycles), .rx_low_current(rx_low_current));
`default_nettype wire
